/* File: hdl/dfc_controller.sv */
// external debug command controller end of the link
`timescale 1ns/1ps
`include "dfc_defines.svh"
module dfc_controller #(
	parameter int HALF_CYCLES = `DFC_TCK_HALF
) (
	input  wire logic  MCLK,
	input  wire logic  RESET_N,
	dfc_link_if.ctl    LINK,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic  REG_WR,
	input  wire logic  REG_RD,
	output logic [31:0] REG_RDATA
);
	dfc_pkg::dfc_ctl_s_t q;
	dfc_pkg::dfc_ctl_s_t d;

	// next state of the whole controller
	always_comb begin
		d = q;
		d.tdo_sy  = {q.tdo_sy[0], LINK.tdo};
		d.ack_sy  = {q.ack_sy[0], LINK.cmd_ack};
		d.de_sy   = {q.de_sy[0], LINK.debug_event_line_n};
		d.stat_sy = {q.stat_sy[1:0], LINK.core_status_hi, LINK.core_status_lo};
		d.rdata   = '0;
		if (REG_RD) begin
			case (REG_ADDR)
				`DFC_REG_DATA: d.rdata = {8'h00, q.rx};
				`DFC_REG_STATUS: begin
					d.rdata[`DFC_STAT_LO]    = q.stat_sy[2];
					d.rdata[`DFC_STAT_HI]    = q.stat_sy[3];
					d.rdata[`DFC_STAT_BUSY]  = (q.st != dfc_pkg::CTL_IDLE);
					d.rdata[`DFC_STAT_DELOW] = !q.de_sy[1];
				end
				default: d.rdata = '0;
			endcase
		end
		if (REG_WR && REG_ADDR == `DFC_REG_DATA) begin
			d.wdata = REG_WDATA[`DFC_DATA_W-1:0];
		end
		case (q.st)
			dfc_pkg::CTL_IDLE: begin
				if (REG_WR && REG_ADDR == `DFC_REG_CTRL && REG_WDATA[`DFC_CTRL_DBGREQ]) begin
					d.de_oe = 1'b1; // pull the event line low to request debug
					d.st    = dfc_pkg::CTL_REQ;
				end else if (REG_WR && REG_ADDR == `DFC_REG_CMD) begin
					d.tx    = {q.wdata, REG_WDATA[7:0]};
					d.tdi   = REG_WDATA[0];
					d.tck   = 1'b0;
					d.hcnt  = '0;
					d.bits  = (REG_WDATA[7:6] == `DFC_CLS_NONE) ? 6'h08 : 6'h20;
					d.st    = dfc_pkg::CTL_SHIFT;
				end
			end
			dfc_pkg::CTL_REQ: begin
				// status bits show debug entry, then let go of the line
				if (q.stat_sy[3:2] == `DFC_STATUS_DEBUG) begin
					d.de_oe = 1'b0;
					d.st    = dfc_pkg::CTL_REL;
				end
			end
			dfc_pkg::CTL_REL: begin
				if (q.de_sy[1]) begin
					d.st = dfc_pkg::CTL_IDLE;
				end
			end
			dfc_pkg::CTL_SHIFT: begin
				if (q.hcnt == 8'(HALF_CYCLES - 1)) begin
					d.hcnt = '0;
					if (!q.tck) begin
						d.tck = 1'b1;
						d.rx  = {q.tdo_sy[1], q.rx[`DFC_DATA_W-1:1]};
					end else begin
						d.tck  = 1'b0;
						d.tx   = {1'b0, q.tx[31:1]};
						d.tdi  = q.tx[1];
						d.bits = q.bits - 6'h01;
						if (q.bits == 6'h01) begin
							d.tdi = 1'b0;
							d.st  = dfc_pkg::CTL_ACK;
						end
					end
				end else begin
					d.hcnt = q.hcnt + 8'h01;
				end
			end
			dfc_pkg::CTL_ACK: begin
				// no new command until the device acknowledges
				if (q.ack_sy[1]) begin
					d.st = dfc_pkg::CTL_IDLE;
				end
			end
			default: d.st = dfc_pkg::CTL_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q         <= '0;
			q.de_sy   <= 2'h3;
			q.st      <= dfc_pkg::CTL_IDLE;
		end else begin
			q <= d;
		end
	end

	assign LINK.tck       = q.tck;
	assign LINK.tdi       = q.tdi;
	assign LINK.ctl_de_o  = 1'b0;
	assign LINK.ctl_de_oe = q.de_oe;
	assign REG_RDATA      = q.rdata;
endmodule : dfc_controller

/* File: hdl/dfc_device.sv */
// core-side end: program flow history ring and serial command engine
`timescale 1ns/1ps
`include "dfc_defines.svh"
// Notes on behaviour
// - record last instruction and flow changes in eight entries
// - ring of eight 17-bit entries, 4-bit pointer
// - one read address; each read advances pointer
// - debug activity leaves history contents untouched
// - on entry pointer selects last executed entry
// - reads run oldest to newest
// - controller always reads all eight entries; here it reads one entry per history read command
// - flow change stores instruction and target
// - not-taken conditional stores no target
// - not-taken flag bit in each entry
// - controller shifts all seventeen entry bits
// - entries shift LSB first, flag first
// - controller waits for entry acknowledge
// - 8-bit commands, optional 24-bit data
// - commands and data shift LSB first
// - each command acknowledged before next one
// - read, write and no-data command classes
// - on entry set status bits, pulse event
// - controller releases event line before commanding
module dfc_device #(
	parameter int ACK_CYCLES = `DFC_ACK_CYCLES
) (
	input  wire logic                   MCLK,
	input  wire logic                   RESET_N,
	dfc_link_if.dev                     LINK,
	input  wire logic                   CORE_HALT_REQ,
	input  wire logic                   INSTR_VALID,
	input  wire logic [`DFC_ADDR_W-1:0] INSTR_ADDR,
	input  wire logic                   COF,
	input  wire logic                   COF_COND,
	input  wire logic                   COF_TAKEN,
	input  wire logic [`DFC_ADDR_W-1:0] COF_TARGET,
	output logic                        IN_DEBUG,
	output logic [`DFC_DATA_W-1:0]      DEBUG_REG
);
	dfc_pkg::dfc_dev_s_t q;
	dfc_pkg::dfc_dev_s_t d;

	// pointer step with wrap at the last entry
	function automatic logic [`DFC_PTR_W-1:0] ptr_inc(input logic [`DFC_PTR_W-1:0] p);
		ptr_inc = (p == `DFC_LAST_IDX) ? '0 : p + 4'h1;
	endfunction : ptr_inc

	logic                   tck_rise;
	logic                   de_fall;
	logic                   bit_in;
	logic [`DFC_CMD_W-1:0]  cmd_full;
	logic [`DFC_PTR_W-1:0]  slot;
	logic [`DFC_PTR_W-1:0]  slot_next;
	logic [`DFC_PTR_W-1:0]  oldest;
	logic                   taken;

	// edges seen through the synchronisers
	assign tck_rise = q.tck_sy[1] && !q.tck_sy[2];
	assign de_fall  = !q.de_sy[1] && q.de_sy[2];
	assign bit_in   = q.tdi_sy[1];
	assign cmd_full = {bit_in, q.cmd[`DFC_CMD_W-1:1]};
	assign taken    = !COF_COND || COF_TAKEN;
	assign slot     = q.sticky ? ptr_inc(q.ptr) : q.ptr;
	// target slot and the entry just past the last executed one
	assign slot_next = ptr_inc(slot);
	assign oldest    = ptr_inc(q.ptr);

	// next state of the whole device
	always_comb begin
		d = q;
		d.tck_sy = {q.tck_sy[1:0], LINK.tck};
		d.tdi_sy = {q.tdi_sy[0], LINK.tdi};
		d.de_sy  = {q.de_sy[1:0], LINK.debug_event_line_n};

		// history capture, only while running
		if (!q.dbg && INSTR_VALID) begin
			if (COF) begin
				d.hist[slot[2:0]].addr      = INSTR_ADDR;
				d.hist[slot[2:0]].not_taken = COF_COND && !COF_TAKEN;
				if (taken) begin
					d.hist[slot_next[2:0]] = '{addr: COF_TARGET, not_taken: 1'b0};
				end
				d.ptr    = slot;
				d.sticky = 1'b1;
				if (taken) begin
					d.ptr = ptr_inc(slot);
				end
			end else begin
				// plain instruction overwrites the scratch slot
				d.hist[slot[2:0]] = '{addr: INSTR_ADDR, not_taken: 1'b0};
				d.ptr             = slot;
				d.sticky          = 1'b0;
			end
		end

		// debug entry: status bits and acknowledge pulse
		if (!q.dbg && (CORE_HALT_REQ || de_fall)) begin
			d.dbg     = 1'b1;
			d.status  = `DFC_STATUS_DEBUG;
			d.de_oe   = 1'b1;
			d.ack_cnt = 8'(ACK_CYCLES - 1);
			d.st      = dfc_pkg::DEV_CMD;
			d.bitcnt  = '0;
		end else if (q.de_oe) begin
			d.ack_cnt = q.ack_cnt - 8'h01;
			if (q.ack_cnt == '0) begin
				d.de_oe = 1'b0;
			end
		end

		// serial command engine, sampled on link clock rise
		if (q.dbg && tck_rise) begin
			d.bitcnt = q.bitcnt + 5'h01;
			case (q.st)
				dfc_pkg::DEV_CMD: begin
					d.cmd = cmd_full;
					if (q.bitcnt == '0) begin
						d.ack = 1'b0;
					end
					if (q.bitcnt == 5'h07) begin
						d.bitcnt = '0;
						case (cmd_full[7:6])
							`DFC_CLS_READ: begin
								d.st = dfc_pkg::DEV_RDATA;
								d.sh = '0;
								if (cmd_full == `DFC_CMD_RD_HIST) begin
									// oldest entry sits just past the last executed
									d.sh  = {7'h00, q.hist[oldest[2:0]]};
									d.ptr = ptr_inc(q.ptr);
								end else if (cmd_full == `DFC_CMD_RD_DREG) begin
									d.sh = q.dreg;
								end
								d.tdo = d.sh[0];
							end
							`DFC_CLS_WRITE: d.st = dfc_pkg::DEV_WDATA;
							default: begin
								d.ack = 1'b1;
								if (cmd_full == `DFC_CMD_GO) begin
									d.dbg    = 1'b0;
									d.status = '0;
									d.de_oe  = 1'b0;
								end
							end
						endcase
					end
				end
				dfc_pkg::DEV_WDATA: begin
					d.sh = {bit_in, q.sh[`DFC_DATA_W-1:1]};
					if (q.bitcnt == 5'h17) begin
						d.bitcnt = '0;
						d.dreg   = {bit_in, q.sh[`DFC_DATA_W-1:1]};
						d.ack    = 1'b1;
						d.st     = dfc_pkg::DEV_CMD;
					end
				end
				dfc_pkg::DEV_RDATA: begin
					d.sh  = {1'b0, q.sh[`DFC_DATA_W-1:1]};
					d.tdo = q.sh[1];
					if (q.bitcnt == 5'h17) begin
						d.bitcnt = '0;
						d.tdo    = 1'b0;
						d.ack    = 1'b1;
						d.st     = dfc_pkg::DEV_CMD;
					end
				end
				default: d.st = dfc_pkg::DEV_CMD;
			endcase
		end else if (!q.dbg) begin
			d.st     = dfc_pkg::DEV_CMD;
			d.bitcnt = '0;
		end
	end

	// state register
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q       <= '0;
			q.de_sy <= 3'h7;
			q.st    <= dfc_pkg::DEV_CMD;
		end else begin
			q <= d;
		end
	end

	assign LINK.tdo            = q.tdo;
	assign LINK.cmd_ack        = q.ack;
	assign LINK.core_status_hi = q.status[1];
	assign LINK.core_status_lo = q.status[0];
	assign LINK.dev_de_o       = 1'b0;
	assign LINK.dev_de_oe      = q.de_oe;
	assign IN_DEBUG            = q.dbg;
	assign DEBUG_REG           = q.dreg;
endmodule : dfc_device

/* File: include/dfc_defines.svh */
// constants for the flow history and debug command link
`ifndef DFC_DEFINES_SVH
`define DFC_DEFINES_SVH
`define DFC_CLK_NS       8
`define DFC_ADDR_W       16
`define DFC_ENTRY_W      17
`define DFC_DEPTH        8
`define DFC_PTR_W        4
`define DFC_LAST_IDX     4'h7
`define DFC_CMD_W        8
`define DFC_DATA_W       24
// command classes in bits 7:6
`define DFC_CLS_NONE     2'h0
`define DFC_CLS_WRITE    2'h1
`define DFC_CLS_READ     2'h2
// command codes
`define DFC_CMD_NOP      8'h00
`define DFC_CMD_GO       8'h01
`define DFC_CMD_WR_DREG  8'h41
`define DFC_CMD_RD_HIST  8'h81
`define DFC_CMD_RD_DREG  8'h82
// debug entry acknowledge pulse on the event line
`define DFC_ACK_NS       256
`define DFC_ACK_CYCLES   (`DFC_ACK_NS / `DFC_CLK_NS)
// half period of the controller's link clock
`define DFC_TCK_HALF_NS  64
`define DFC_TCK_HALF     (`DFC_TCK_HALF_NS / `DFC_CLK_NS)
// controller register offsets
`define DFC_REG_CTRL     8'h00
`define DFC_REG_CMD      8'h04
`define DFC_REG_DATA     8'h08
`define DFC_REG_STATUS   8'h0C
// controller field positions
`define DFC_CTRL_DBGREQ  0
`define DFC_STAT_LO      0
`define DFC_STAT_HI      1
`define DFC_STAT_BUSY    2
`define DFC_STAT_DELOW   3
`define DFC_STATUS_DEBUG 2'h3
`endif

/* File: include/dfc_link_if.sv */
// serial debug link between the core side and the command controller
`timescale 1ns/1ps
interface dfc_link_if;
	logic tck;
	logic tdi;
	logic tdo;
	logic cmd_ack;
	logic core_status_hi;
	logic core_status_lo;
	logic dev_de_o;
	logic dev_de_oe;
	logic ctl_de_o;
	logic ctl_de_oe;
	logic debug_event_line_n;

	// open-drain wire, pulled high when nobody drives low
	assign debug_event_line_n = !((dev_de_oe && !dev_de_o) || (ctl_de_oe && !ctl_de_o));

	modport dev (input tck, tdi, debug_event_line_n,
		output tdo, cmd_ack, core_status_hi, core_status_lo, dev_de_o, dev_de_oe);
	modport ctl (input tdo, cmd_ack, core_status_hi, core_status_lo, debug_event_line_n,
		output tck, tdi, ctl_de_o, ctl_de_oe);
endinterface : dfc_link_if

/* File: include/dfc_pkg.sv */
// types for the flow history and debug command link
`include "dfc_defines.svh"
package dfc_pkg;
	typedef struct packed {
		logic [`DFC_ADDR_W-1:0] addr;
		logic                   not_taken;
	} dfc_entry_t;

	typedef enum logic [1:0] {
		DEV_CMD   = 2'h0,
		DEV_WDATA = 2'h1,
		DEV_RDATA = 2'h3
	} dfc_dev_st_t;

	typedef enum logic [2:0] {
		CTL_IDLE  = 3'h0,
		CTL_SHIFT = 3'h1,
		CTL_ACK   = 3'h3,
		CTL_REQ   = 3'h4,
		CTL_REL   = 3'h6
	} dfc_ctl_st_t;

	typedef struct packed {
		logic [2:0]                   tck_sy;
		logic [1:0]                   tdi_sy;
		logic [2:0]                   de_sy;
		logic                         dbg;
		logic [1:0]                   status;
		logic                         de_oe;
		logic [7:0]                   ack_cnt;
		logic                         ack;
		dfc_dev_st_t                  st;
		logic [4:0]                   bitcnt;
		logic [`DFC_CMD_W-1:0]        cmd;
		logic [`DFC_DATA_W-1:0]       sh;
		logic                         tdo;
		dfc_entry_t [`DFC_DEPTH-1:0]  hist;
		logic [`DFC_PTR_W-1:0]        ptr;
		logic                         sticky;
		logic [`DFC_DATA_W-1:0]       dreg;
	} dfc_dev_s_t;

	typedef struct packed {
		dfc_ctl_st_t                  st;
		logic [7:0]                   hcnt;
		logic                         tck;
		logic                         tdi;
		logic [5:0]                   bits;
		logic [31:0]                  tx;
		logic [`DFC_DATA_W-1:0]       rx;
		logic [`DFC_DATA_W-1:0]       wdata;
		logic                         de_oe;
		logic [1:0]                   tdo_sy;
		logic [1:0]                   ack_sy;
		logic [1:0]                   de_sy;
		logic [3:0]                   stat_sy;
		logic [31:0]                  rdata;
	} dfc_ctl_s_t;
endpackage : dfc_pkg

/* File: testbench/dfc_link_props.sv */
// link checker: timing and handshake relations on the debug link
`timescale 1ns/1ps
module dfc_link_props #(
	parameter int ACK_CYCLES  = 32,
	parameter int HALF_CYCLES = 8
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic tck,
	input wire logic tdi,
	input wire logic cmd_ack,
	input wire logic core_status_hi,
	input wire logic core_status_lo,
	input wire logic dev_de_oe,
	input wire logic debug_event_line_n
);
	logic [7:0] oe_cnt_r;
	logic [7:0] hi_cnt_r;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	// length of the entry pulse and of the tck high phase
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			oe_cnt_r <= 8'h00;
			hi_cnt_r <= 8'h00;
		end else begin
			oe_cnt_r <= dev_de_oe ? oe_cnt_r + 8'h01 : 8'h00;
			hi_cnt_r <= tck ? hi_cnt_r + 8'h01 : 8'h00;
		end
	end
	// first part of the entry acknowledge
	sequence oe_pulse_s;
		dev_de_oe [*4];
	endsequence
	status_pair_a: assert property (core_status_hi == core_status_lo)
		else $error("status bits differ");
	entry_ack_a: assert property ($rose(core_status_hi) |-> oe_pulse_s)
		else $error("no event pulse on entry");
	ack_len_a: assert property ($fell(dev_de_oe) |-> oe_cnt_r == ACK_CYCLES)
		else $error("event pulse length wrong");
	oe_debug_a: assert property (dev_de_oe |-> core_status_hi)
		else $error("event pulse outside debug");
	tck_half_a: assert property ($fell(tck) |-> hi_cnt_r == HALF_CYCLES)
		else $error("tck high phase wrong");
	tdi_hold_a: assert property (tck && $past(tck) |-> $stable(tdi))
		else $error("tdi moved while tck high");
	ack_rise_a: assert property ($rose(cmd_ack) |-> tck)
		else $error("ack rose off a sampled bit");
	ack_fall_a: assert property ($fell(cmd_ack) |-> tck)
		else $error("ack fell off a sampled bit");
	line_free_a: assert property ($rose(tck) |-> debug_event_line_n)
		else $error("shifting while event line low");
	leave_go_a: assert property ($fell(core_status_hi) |-> tck)
		else $error("debug left without command");
endmodule : dfc_link_props

/* File: testbench/dfc_tb.sv */
// self-checking bench: both link ends joined, run through registers and core inputs
`timescale 1ns/1ps
`include "dfc_defines.svh"
module dfc_tb;
	logic        mclk;
	logic        reset_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        halt_req;
	logic        ivalid;
	logic [15:0] iaddr;
	logic [2:0]  iflags;
	logic [15:0] itarget;
	logic        in_debug;
	logic [23:0] debug_reg;
	int          num_errors;
	int          checks;
	int          cyc;
	logic        last_cof;
	logic        halted;
	logic [16:0] hq[$];
	logic [31:0] rd;
	dfc_link_if link ();
	dfc_controller #(.HALF_CYCLES(8)) u_dfc_controller (.MCLK(mclk), .RESET_N(reset_n),
		.LINK(link), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata));
	dfc_device #(.ACK_CYCLES(8)) u_dfc_device (.MCLK(mclk), .RESET_N(reset_n), .LINK(link),
		.CORE_HALT_REQ(halt_req), .INSTR_VALID(ivalid), .INSTR_ADDR(iaddr), .COF(iflags[2]),
		.COF_COND(iflags[1]), .COF_TAKEN(iflags[0]), .COF_TARGET(itarget),
		.IN_DEBUG(in_debug), .DEBUG_REG(debug_reg));
	dfc_link_props #(.ACK_CYCLES(8), .HALF_CYCLES(8)) u_dfc_link_props (.MCLK(mclk),
		.RESET_N(reset_n), .tck(link.tck), .tdi(link.tdi), .cmd_ack(link.cmd_ack),
		.core_status_hi(link.core_status_hi), .core_status_lo(link.core_status_lo),
		.dev_de_oe(link.dev_de_oe), .debug_event_line_n(link.debug_event_line_n));
	// clock
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	task automatic end_sim();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : chk
	task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : reg_wr_t
	task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask : reg_rd_t
	// poll status until it matches, bounded
	task automatic wait_stat(input logic [31:0] exp);
		int n;
		n = 0;
		do begin
			reg_rd_t(`DFC_REG_STATUS, rd);
			n++;
		end while (rd !== exp && n < 3000);
		chk(exp, rd);
	endtask : wait_stat
	task automatic cmd_t(input logic [7:0] c, input logic [31:0] st);
		reg_wr_t(`DFC_REG_CMD, {24'h00_0000, c});
		wait_stat(st);
	endtask : cmd_t
	// one executed instruction; flags are change of flow, conditional, taken
	task automatic run(input logic [15:0] a, input logic [2:0] f, input logic [15:0] t);
		@(posedge mclk);
		ivalid  <= 1'h1;
		iaddr   <= a;
		iflags  <= f;
		itarget <= t;
		@(posedge mclk);
		ivalid <= 1'h0;
		// a flow change after a plain instruction takes over its slot
		if (!halted && f[2]) begin
			if (last_cof) hq.push_back({a, f[1] & !f[0]});
			else hq[hq.size() - 1] = {a, f[1] & !f[0]};
			if (!f[1] || f[0]) hq.push_back({t, 1'h0});
		end else if (!halted && last_cof) hq.push_back({a, 1'h0});
		else if (!halted) hq[hq.size() - 1] = {a, 1'h0};
		if (!halted) last_cof = f[2];
	endtask : run
	// two full passes over the ring, oldest entry first
	task automatic hist_chk();
		for (int i = 0; i < 16; i++) begin
			cmd_t(`DFC_CMD_RD_HIST, 32'h0000_0003);
			reg_rd_t(`DFC_REG_DATA, rd);
			chk({15'h0000, hq[hq.size() - 8 + i % 8]}, rd);
		end
	endtask : hist_chk
	// cycle limit
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 80000) begin
			num_errors++;
			end_sim();
		end
	end
	// main sequence
	initial begin
		{reset_n, reg_wr, reg_rd, halt_req, ivalid, halted} = 6'h00;
		{reg_addr, reg_wdata, iaddr, iflags, itarget} = 75'h0;
		{num_errors, checks, cyc} = 96'h0;
		last_cof = 1'h1;
		repeat (16) @(posedge mclk);
		reset_n <= 1'h1;
		reg_rd_t(`DFC_REG_STATUS, rd);
		chk(32'h0000_0000, rd);
		run(16'h0110, 3'h6, 16'h0111);
		run(16'h0120, 3'h4, 16'h0300);
		run(16'h0301, 3'h7, 16'h0400);
		run(16'h0402, 3'h6, 16'h0403);
		run(16'h0403, 3'h4, 16'h0500);
		run(16'h0501, 3'h0, 16'h0000);
		run(16'h0502, 3'h0, 16'h0000);
		halt_req <= 1'h1;
		wait_stat(32'h0000_0003);
		halt_req <= 1'h0;
		chk(32'h0000_0001, {31'h0, in_debug});
		halted = 1'h1;
		run(16'h0777, 3'h5, 16'h0778);
		hist_chk();
		reg_wr_t(`DFC_REG_DATA, 32'h00A5_C31E);
		cmd_t(`DFC_CMD_WR_DREG, 32'h0000_0003);
		chk(32'h00A5_C31E, {8'h00, debug_reg});
		cmd_t(`DFC_CMD_RD_DREG, 32'h0000_0003);
		reg_rd_t(`DFC_REG_DATA, rd);
		chk(32'h00A5_C31E, rd);
		cmd_t(`DFC_CMD_NOP, 32'h0000_0003);
		cmd_t(8'h83, 32'h0000_0003);
		reg_rd_t(`DFC_REG_DATA, rd);
		chk(32'h0000_0000, rd);
		reg_rd_t(8'h10, rd);
		chk(32'h0000_0000, rd);
		cmd_t(`DFC_CMD_GO, 32'h0000_0000);
		chk(32'h0000_0000, {31'h0, in_debug});
		halted = 1'h0;
		run(16'h0600, 3'h4, 16'h0700);
		run(16'h0701, 3'h0, 16'h0000);
		reg_wr_t(`DFC_REG_CTRL, 32'h0000_0001);
		wait_stat(32'h0000_0003);
		hist_chk();
		end_sim();
	end
endmodule : dfc_tb
